// ==== inc/dip_map.svh ====
// register map, field positions, reset values and timing of the selector
`ifndef DIP_MAP_SVH
`define DIP_MAP_SVH
`define DIP_ADDR_CTRL  8'h0F
`define DIP_BIT_OVR    2
`define DIP_BIT_SEL    1
`define DIP_ADDR_PWR   8'h14
`define DIP_BIT_PWR    1
`define DIP_ADDR_DET   8'h15
`define DIP_BIT_HS     7
`define DIP_BIT_SOG    6
`define DIP_BIT_VS     5
`define DIP_BIT_LCK    4
`define DIP_ADDR_FMT   8'h16
`define DIP_BIT_FMT    0
`define DIP_ADDR_STAT  8'h17
`define DIP_BIT_QUAL   2
`define DIP_MODE_HI    1
`define DIP_MODE_LO    0
`define DIP_PWR_RST    1'b1
`define DIP_OVR_RST    1'b0
`define DIP_SEL_RST    1'b0
`define DIP_FMT_RST    1'b0
`define DIP_DE_NEEDED  6'h20
`define DIP_LOSS_MS    100
`define DIP_CLK_MHZ    25
`define DIP_LOSS_CYC   (`DIP_LOSS_MS * 1000 * `DIP_CLK_MHZ)
`define DIP_SYNC_LAG   3
`endif

// ==== inc/dip_pkg.sv ====
// types shared by the interface selector
package dip_pkg;
  typedef enum logic [1:0] {
    DIP_SEEK    = 2'b00,
    DIP_ANALOG  = 2'b01,
    DIP_DIGITAL = 2'b10,
    DIP_OFF     = 2'b11
  } dip_mode_type;
endpackage

// ==== rtl/dip_act_det.sv ====
// activity detector: edge seen recently on a pin
`timescale 1ns/1ps
`include "dip_map.svh"
module dip_act_det #(
  parameter int unsigned LOSS_CYCLES = `DIP_LOSS_CYC
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // control and pin
  input  wire logic enable,
  input  wire logic pin,
  // result
  output logic      active,
  output logic      rise
);
  localparam logic [21:0] LIMIT = 22'(LOSS_CYCLES - `DIP_SYNC_LAG);
  logic [2:0]  sync;
  logic [21:0] idle;
  logic [2:0]  next_sync;
  logic [21:0] next_idle;
  logic        next_active;

  assign rise = sync[1] & ~sync[2];

  always_comb begin
    next_sync   = {sync[1:0], pin};
    next_idle   = idle;
    next_active = active;
    if (!enable) begin
      next_idle   = 22'h000000;
      next_active = 1'b0;
    end else if (rise) begin
      next_idle   = 22'h000000;
      next_active = 1'b1;
    end else if (idle >= LIMIT) begin
      next_active = 1'b0;
    end else begin
      next_idle = idle + 22'h000001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sync   <= 3'h0;
      idle   <= 22'h000000;
      active <= 1'b0;
    end else begin
      sync   <= next_sync;
      idle   <= next_idle;
      active <= next_active;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_loss_clear: assert property (
    enable && !rise && idle >= LIMIT |=> !active)
    else $error("activity not cleared after loss time");
  a_edge_sets: assert property (
    enable && rise |=> active && idle == 22'h000000)
    else $error("edge did not mark activity");
endmodule

// ==== rtl/dip_top.sv ====
// interface detect and power selection for the dual video input
`timescale 1ns/1ps
`include "dip_map.svh"
module dip_top #(
  parameter int unsigned LOSS_CYCLES = `DIP_LOSS_CYC
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // activity pins
  input  wire logic       hsync_in,
  input  wire logic       vsync_in,
  input  wire logic       green_embedded_sync,
  input  wire logic       link_clk_in,
  input  wire logic       de_in,
  // pixel sources
  input  wire logic [7:0] ana_red,
  input  wire logic [7:0] ana_green,
  input  wire logic [7:0] ana_blue,
  input  wire logic [7:0] dig_red,
  input  wire logic [7:0] dig_green,
  input  wire logic [7:0] dig_blue,
  // shared pixel outputs
  output logic      [7:0] red_out,
  output logic      [7:0] green_out,
  output logic      [7:0] blue_out,
  // power enables and state
  output logic            pwr_ana_core,
  output logic            pwr_dig_core,
  output logic            pwr_bandgap,
  output logic            pwr_hs_det,
  output logic            pwr_vs_det,
  output logic            pwr_sog_det,
  output logic            pwr_lck_det,
  output logic            pwr_red_out,
  output logic            pwr_green_out,
  output logic            pwr_blue_out,
  output dip_pkg::dip_mode_type mode
);
  // control registers
  logic active_override_bit;
  logic active_select_bit;
  logic pwr_on;
  logic fmt_422;
  logic next_ovr, next_sel, next_pwr, next_fmt;
  logic [7:0] next_rdata;
  // detection
  logic       hs_act, vs_act, sog_act, lck_act, de_act, de_rise;
  logic       ana_det, dig_qual, qualify;
  logic [5:0] de_cnt;
  logic [5:0] next_de_cnt;
  // selection and power
  dip_pkg::dip_mode_type next_mode;
  logic next_ana_core, next_dig_core, next_bandgap;
  logic next_hs_det, next_vs_det, next_sog_det, next_lck_det;
  logic next_red_pw, next_green_pw, next_blue_pw;
  logic [7:0] next_red, next_green, next_blue;
  function automatic dip_pkg::dip_mode_type pick_mode(
    input logic pwr, input logic ovr, input logic sel,
    input logic ana, input logic dig);
    dip_pkg::dip_mode_type m;
    m = dip_pkg::DIP_SEEK;
    if (!pwr) begin
      m = dip_pkg::DIP_OFF;
    end else if (ovr) begin
      m = sel ? dip_pkg::DIP_DIGITAL : dip_pkg::DIP_ANALOG;
    end else if (ana && dig) begin
      m = sel ? dip_pkg::DIP_DIGITAL : dip_pkg::DIP_ANALOG;
    end else if (ana) begin
      m = dip_pkg::DIP_ANALOG;
    end else if (dig) begin
      m = dip_pkg::DIP_DIGITAL;
    end
    return m;
  endfunction

  // activity detectors
  dip_act_det #(.LOSS_CYCLES(LOSS_CYCLES)) u_hs (
    .ref_clk(ref_clk), .resetn(resetn), .enable(pwr_on),
    .pin(hsync_in), .active(hs_act), .rise());
  dip_act_det #(.LOSS_CYCLES(LOSS_CYCLES)) u_vs (
    .ref_clk(ref_clk), .resetn(resetn), .enable(pwr_on),
    .pin(vsync_in), .active(vs_act), .rise());
  dip_act_det #(.LOSS_CYCLES(LOSS_CYCLES)) u_sog (
    .ref_clk(ref_clk), .resetn(resetn), .enable(pwr_on),
    .pin(green_embedded_sync), .active(sog_act), .rise());
  dip_act_det #(.LOSS_CYCLES(LOSS_CYCLES)) u_lck (
    .ref_clk(ref_clk), .resetn(resetn), .enable(pwr_on),
    .pin(link_clk_in), .active(lck_act), .rise());
  dip_act_det #(.LOSS_CYCLES(LOSS_CYCLES)) u_de (
    .ref_clk(ref_clk), .resetn(resetn), .enable(pwr_dig_core),
    .pin(de_in), .active(de_act), .rise(de_rise));
  assign ana_det  = hs_act | vs_act | sog_act;
  assign dig_qual = (de_cnt == `DIP_DE_NEEDED);
  assign qualify  = lck_act && !dig_qual && mode == dip_pkg::DIP_SEEK;
  // DE qualification counter
  always_comb begin
    next_de_cnt = de_cnt;
    if (!lck_act) begin
      next_de_cnt = 6'h00;
    end else if (dig_qual) begin
      next_de_cnt = de_cnt;
    end else if (pwr_dig_core && !de_act) begin
      next_de_cnt = 6'h00;
    end else if (pwr_dig_core && de_rise) begin
      next_de_cnt = de_cnt + 6'h01;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      de_cnt <= 6'h00;
    end else begin
      de_cnt <= next_de_cnt;
    end
  end
  // register port
  always_comb begin
    next_ovr   = active_override_bit;
    next_sel   = active_select_bit;
    next_pwr   = pwr_on;
    next_fmt   = fmt_422;
    next_rdata = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        `DIP_ADDR_CTRL: begin
          next_ovr = reg_wdata[`DIP_BIT_OVR];
          next_sel = reg_wdata[`DIP_BIT_SEL];
        end
        `DIP_ADDR_PWR: next_pwr = reg_wdata[`DIP_BIT_PWR];
        `DIP_ADDR_FMT: next_fmt = reg_wdata[`DIP_BIT_FMT];
        default: next_pwr = pwr_on;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `DIP_ADDR_CTRL: begin
          next_rdata[`DIP_BIT_OVR] = active_override_bit;
          next_rdata[`DIP_BIT_SEL] = active_select_bit;
        end
        `DIP_ADDR_PWR: next_rdata[`DIP_BIT_PWR] = pwr_on;
        `DIP_ADDR_DET: begin
          next_rdata[`DIP_BIT_HS]  = hs_act;
          next_rdata[`DIP_BIT_VS]  = vs_act;
          next_rdata[`DIP_BIT_SOG] = sog_act;
          next_rdata[`DIP_BIT_LCK] = lck_act;
        end
        `DIP_ADDR_FMT: next_rdata[`DIP_BIT_FMT] = fmt_422;
        `DIP_ADDR_STAT: begin
          next_rdata[`DIP_MODE_HI:`DIP_MODE_LO] = mode;
          next_rdata[`DIP_BIT_QUAL] = dig_qual;
        end
        default: next_rdata = 8'h00;
      endcase
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      active_override_bit <= `DIP_OVR_RST;
      active_select_bit   <= `DIP_SEL_RST;
      pwr_on              <= `DIP_PWR_RST;
      fmt_422             <= `DIP_FMT_RST;
      reg_rdata           <= 8'h00;
    end else begin
      active_override_bit <= next_ovr;
      active_select_bit   <= next_sel;
      pwr_on              <= next_pwr;
      fmt_422             <= next_fmt;
      reg_rdata           <= next_rdata;
    end
  end
  // mode, power plan and pixel routing
  always_comb begin
    next_mode = pick_mode(pwr_on, active_override_bit, active_select_bit,
                          ana_det, dig_qual);
    next_ana_core = 1'b0;
    next_dig_core = 1'b0;
    next_bandgap  = 1'b0;
    next_hs_det   = 1'b0;
    next_vs_det   = 1'b0;
    next_sog_det  = 1'b0;
    next_lck_det  = 1'b0;
    next_red_pw   = 1'b0;
    next_green_pw = 1'b0;
    next_blue_pw  = 1'b0;
    next_red      = 8'h00;
    next_green    = 8'h00;
    next_blue     = 8'h00;
    case (mode)
      dip_pkg::DIP_SEEK: begin
        next_hs_det   = 1'b1;
        next_lck_det  = 1'b1;
        next_sog_det  = 1'b1;
        next_dig_core = qualify;
      end
      dip_pkg::DIP_DIGITAL: begin
        next_dig_core = 1'b1;
        next_bandgap  = 1'b1;
        next_hs_det   = 1'b1;
        next_vs_det   = 1'b1;
        next_sog_det  = 1'b1;
        next_lck_det  = 1'b1;
        next_red_pw   = 1'b1;
        next_green_pw = 1'b1;
        next_blue_pw  = 1'b1;
        next_red      = dig_red;
        next_green    = dig_green;
        next_blue     = dig_blue;
      end
      dip_pkg::DIP_ANALOG: begin
        next_ana_core = 1'b1;
        next_bandgap  = 1'b1;
        next_hs_det   = 1'b1;
        next_vs_det   = 1'b1;
        next_sog_det  = 1'b1;
        next_lck_det  = 1'b1;
        next_red_pw   = 1'b1;
        next_green_pw = 1'b1;
        next_blue_pw  = !fmt_422;
        next_red      = ana_red;
        next_green    = ana_green;
        next_blue     = fmt_422 ? 8'h00 : ana_blue;
      end
      default: next_ana_core = 1'b0;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mode          <= dip_pkg::DIP_SEEK;
      pwr_ana_core  <= 1'b0;
      pwr_dig_core  <= 1'b0;
      pwr_bandgap   <= 1'b0;
      pwr_hs_det    <= 1'b0;
      pwr_vs_det    <= 1'b0;
      pwr_sog_det   <= 1'b0;
      pwr_lck_det   <= 1'b0;
      pwr_red_out   <= 1'b0;
      pwr_green_out <= 1'b0;
      pwr_blue_out  <= 1'b0;
      red_out       <= 8'h00;
      green_out     <= 8'h00;
      blue_out      <= 8'h00;
    end else begin
      mode          <= next_mode;
      pwr_ana_core  <= next_ana_core;
      pwr_dig_core  <= next_dig_core;
      pwr_bandgap   <= next_bandgap;
      pwr_hs_det    <= next_hs_det;
      pwr_vs_det    <= next_vs_det;
      pwr_sog_det   <= next_sog_det;
      pwr_lck_det   <= next_lck_det;
      pwr_red_out   <= next_red_pw;
      pwr_green_out <= next_green_pw;
      pwr_blue_out  <= next_blue_pw;
      red_out       <= next_red;
      green_out     <= next_green;
      blue_out      <= next_blue;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_off_req;
    !pwr_on;
  endsequence
  sequence s_all_dark;
    !pwr_ana_core && !pwr_dig_core && !pwr_red_out && !pwr_lck_det;
  endsequence
  sequence s_last_de;
    lck_act && pwr_dig_core && de_act && de_rise
      && de_cnt == `DIP_DE_NEEDED - 6'h01;
  endsequence
  a_power_down_all: assert property (
    s_off_req ##1 !pwr_on |=> s_all_dark)
    else $error("power-down left a circuit powered");
  a_override_pick: assert property (
    pwr_on && active_override_bit |=>
      mode == ($past(active_select_bit) ? dip_pkg::DIP_DIGITAL
                                 : dip_pkg::DIP_ANALOG))
    else $error("override choice not followed");
  a_seek_entry: assert property (
    pwr_on && !active_override_bit && !ana_det && !dig_qual |=>
      mode == dip_pkg::DIP_SEEK ##1 !pwr_ana_core && !pwr_bandgap)
    else $error("seek state not entered");
  a_one_core: assert property (
    !(pwr_ana_core && pwr_dig_core))
    else $error("both interface cores powered");
  a_detect_read: assert property (
    reg_rd && reg_addr == `DIP_ADDR_DET |=>
      reg_rdata[`DIP_BIT_HS] == $past(hs_act) &&
      reg_rdata[`DIP_BIT_VS] == $past(vs_act) &&
      reg_rdata[`DIP_BIT_SOG] == $past(sog_act) &&
      reg_rdata[`DIP_BIT_LCK] == $past(lck_act))
    else $error("detect register mismatch");
  a_de_qualify: assert property (
    s_last_de |=> dig_qual)
    else $error("32nd DE did not qualify digital");
  a_dig_keep: assert property (
    mode == dip_pkg::DIP_DIGITAL |=>
      pwr_bandgap && pwr_hs_det && pwr_vs_det && pwr_sog_det)
    else $error("digital mode dropped detectors");
  a_fmt_blue: assert property (
    mode == dip_pkg::DIP_ANALOG |=>
      pwr_lck_det && pwr_blue_out == !$past(fmt_422))
    else $error("analog power plan wrong");
  a_pixel_route: assert property (
    mode == dip_pkg::DIP_DIGITAL |=> red_out == $past(dig_red))
    else $error("pixel bus not from digital source");
  a_both_prio: assert property (
    pwr_on && !active_override_bit && ana_det && dig_qual |=>
      mode == ($past(active_select_bit) ? dip_pkg::DIP_DIGITAL
                                 : dip_pkg::DIP_ANALOG))
    else $error("both-detected priority wrong");
endmodule

// ==== sim/dip_src.sv ====
// graphics source model: sync pins, link clock, DE and pixel data
`timescale 1ns/1ps
module dip_src (
  // activity enables: hsync, vsync, green sync, link clock, DE
  input  wire logic [4:0] en,
  // pins toward the selector
  output logic            hsync,
  output logic            vsync,
  output logic            gsync,
  output logic            lclk,
  output logic            de,
  // pixel sources
  output logic     [23:0] ana_pix,
  output logic     [23:0] dig_pix
);
  // a disabled line is held low, so it shows no activity
  initial begin
    hsync = 1'b0;
    forever #160 hsync = en[0] ? ~hsync : 1'b0;
  end
  initial begin
    vsync = 1'b0;
    forever #240 vsync = en[1] ? ~vsync : 1'b0;
  end
  initial begin
    gsync = 1'b0;
    forever #200 gsync = en[2] ? ~gsync : 1'b0;
  end
  initial begin
    lclk = 1'b0;
    forever #120 lclk = en[3] ? ~lclk : 1'b0;
  end
  initial begin
    de = 1'b0;
    forever #160 de = en[4] ? ~de : 1'b0;
  end
  assign ana_pix = 24'hA1A2A3;
  assign dig_pix = 24'hB1B2B3;
endmodule

// ==== sim/tb_top.sv ====
// self-checking bench of the interface selector
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; \
  if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_top;
  localparam int LOSS = 64;
  logic        ref_clk, resetn, reg_wr, reg_rd;
  logic  [7:0] reg_addr, reg_wdata, reg_rdata;
  logic  [7:0] red_out, green_out, blue_out;
  logic  [4:0] en;
  logic [23:0] ana_pix, dig_pix;
  logic        hs, vs, gs, lc, de;
  logic  [9:0] pwr;
  dip_pkg::dip_mode_type mode;
  int          fail_count, samples_checked;
  logic        pac, pdc, pbg, phs, pvs, psg, plk, pr, pg, pb;

  assign pwr = {pac, pdc, pbg, phs, pvs, psg, plk, pr, pg, pb};

  dip_src i_src (.en(en), .hsync(hs), .vsync(vs), .gsync(gs), .lclk(lc),
    .de(de), .ana_pix(ana_pix), .dig_pix(dig_pix));

  dip_top #(.LOSS_CYCLES(LOSS)) i_dut (.ref_clk(ref_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hsync_in(hs), .vsync_in(vs),
    .green_embedded_sync(gs), .link_clk_in(lc), .de_in(de),
    .ana_red(ana_pix[23:16]), .ana_green(ana_pix[15:8]),
    .ana_blue(ana_pix[7:0]), .dig_red(dig_pix[23:16]),
    .dig_green(dig_pix[15:8]), .dig_blue(dig_pix[7:0]),
    .red_out(red_out), .green_out(green_out), .blue_out(blue_out),
    .pwr_ana_core(pac), .pwr_dig_core(pdc), .pwr_bandgap(pbg),
    .pwr_hs_det(phs), .pwr_vs_det(pvs), .pwr_sog_det(psg),
    .pwr_lck_det(plk), .pwr_red_out(pr), .pwr_green_out(pg),
    .pwr_blue_out(pb), .mode(mode));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    `CHK("register read", e, reg_rdata)
  endtask

  task wcyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // bounded wait for a mode, then let power and pixels settle
  task wmode(input logic [1:0] e);
    int k;
    k = 0;
    while (mode !== e && k < 1000) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    wcyc(3);
  endtask

  task chk_st(input logic [1:0] m, input logic [9:0] p);
    `CHK("mode", m, mode)
    `CHK("power enables", p, pwr)
  endtask

  task chk_pix(input logic [23:0] e);
    `CHK("pixel outputs", e, {red_out, green_out, blue_out})
  endtask

  task t_reset;
    chk_st(2'h0, 10'h058);
    chk_pix(24'h000000);
    rchk(8'h0F, 8'h00);
    rchk(8'h14, 8'h02);
    rchk(8'h16, 8'h00);
    wr(8'h15, 8'hFF);
    wr(8'h17, 8'hFF);
    wr(8'h20, 8'hFF);
    rchk(8'h15, 8'h00);
    rchk(8'h17, 8'h00);
    rchk(8'h20, 8'h00);
  endtask

  task t_sync_each;
    logic [7:0] bits [3];
    bits = '{8'h80, 8'h20, 8'h40};
    for (int i = 0; i < 3; i++) begin
      en = 5'h01 << i;
      wmode(2'h1);
      chk_st(2'h1, 10'h2FF);
      rchk(8'h15, bits[i]);
      en = 5'h00;
      wcyc(LOSS + 8);
      rchk(8'h15, 8'h00);
      wmode(2'h0);
      chk_st(2'h0, 10'h058);
    end
  endtask

  task t_analog;
    en = 5'h01;
    wmode(2'h1);
    chk_st(2'h1, 10'h2FF);
    chk_pix(24'hA1A2A3);
    wr(8'h16, 8'h01);
    wcyc(4);
    chk_st(2'h1, 10'h2FE);
    chk_pix(24'hA1A200);
    wr(8'h16, 8'h00);
    wcyc(4);
    chk_st(2'h1, 10'h2FF);
    en = 5'h00;
    wmode(2'h0);
  endtask

  task t_digital;
    en = 5'h18;
    wmode(2'h2);
    chk_st(2'h2, 10'h1FF);
    chk_pix(24'hB1B2B3);
    rchk(8'h15, 8'h10);
    rchk(8'h17, 8'h06);
  endtask

  task t_both;
    en = 5'h19;
    wcyc(40);
    chk_st(2'h1, 10'h2FF);
    wr(8'h0F, 8'h02);
    wcyc(4);
    chk_st(2'h2, 10'h1FF);
    wr(8'h0F, 8'h00);
    wcyc(4);
    chk_st(2'h1, 10'h2FF);
  endtask

  task t_override;
    en = 5'h18;
    wcyc(LOSS + 8);
    wmode(2'h2);
    wr(8'h0F, 8'h04);
    wcyc(4);
    chk_st(2'h1, 10'h2FF);
    chk_pix(24'hA1A2A3);
    wr(8'h0F, 8'h06);
    wcyc(4);
    chk_st(2'h2, 10'h1FF);
    wr(8'h0F, 8'h00);
    wcyc(4);
    chk_st(2'h2, 10'h1FF);
  endtask

  task t_loss;
    en = 5'h01;
    wcyc(LOSS + 8);
    rchk(8'h15, 8'h80);
    wmode(2'h1);
    chk_st(2'h1, 10'h2FF);
  endtask

  task t_pdown;
    wr(8'h0F, 8'h06);
    wr(8'h14, 8'h00);
    wcyc(4);
    chk_st(2'h3, 10'h000);
    chk_pix(24'h000000);
    rchk(8'h15, 8'h00);
    rchk(8'h14, 8'h00);
    wr(8'h14, 8'h02);
    wr(8'h0F, 8'h00);
    wmode(2'h1);
    chk_st(2'h1, 10'h2FF);
  endtask

  initial begin
    fail_count      = 0;
    samples_checked = 0;
    resetn    = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    en        = 5'h00;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    wcyc(2);
    t_reset;
    t_sync_each;
    t_analog;
    t_digital;
    t_both;
    t_override;
    t_loss;
    t_pdown;
    close_out;
  end

  initial begin
    #(40 * 30000);
    fail_count++;
    close_out;
  end
endmodule
